// ### eag_consts.vh
// Constants for the effective address generator
`ifndef EAG_CONSTS_VH
`define EAG_CONSTS_VH
`define EAG_XLEN 32
`define EAG_INSN_BYTES 32'h00000004
`define EAG_REG_CNT 32
`define EAG_RF_W 5
`define EAG_IMM_W 16
`define EAG_RESET_PC 32'h00000000
// Instruction field positions
`define EAG_BASE_HI 20
`define EAG_BASE_LO 16
`define EAG_INDEX_HI 15
`define EAG_INDEX_LO 11
`define EAG_IMM_HI 15
`define EAG_IMM_LO 0
// Access kinds
`define EAG_KIND_NONE 3'h0
`define EAG_KIND_INT_LD 3'h1
`define EAG_KIND_INT_ST 3'h2
`define EAG_KIND_FP_LD 3'h3
`define EAG_KIND_FP_ST 3'h4
`define EAG_KIND_BRANCH 3'h5
`define EAG_KIND_ALU 3'h6
// Operand sizes in bytes
`define EAG_SIZE_BYTE 4'h1
`define EAG_SIZE_HALF 4'h2
`define EAG_SIZE_WORD 4'h4
`define EAG_SIZE_DWORD 4'h8
`endif

// ### eag_effective_address_generator.v
// Effective address generation datapath with sequential fetch address
`timescale 1ns/1ps
`include "eag_consts.vh"

// ------------------------------------------------------------------
// Contract
// - Each decoded instruction is one 32-bit word with fixed field positions.
// - Fetch addresses stay word aligned and advance by four bytes.
// - Immediate mode: base, or zero for register 0, plus displacement.
// - Indexed mode: base, or zero for register 0, plus index register.
// - A 32-bit address is produced for accesses, branches and fetch.
// - Aligned access address is computed and registered in one cycle.
// - Bytes of an operand past the top address continue from zero.
// - Address sums are unsigned 32-bit; the carry out is dropped.
// - Arithmetic and logical instructions never issue a memory write.
// - Integer transfers are byte, half or word to 32 general registers.
// - Float transfers are single or double word to 32 float registers.
// ------------------------------------------------------------------
module eag_effective_address_generator (
  input wire clk_i,
  input wire sys_rst_i,
  input wire insn_valid_i,
  input wire [31:0] insn_word_i,
  input wire [2:0] access_kind_i,
  input wire [3:0] access_size_i,
  input wire index_mode_i,
  input wire [31:0] base_value_i,
  input wire [31:0] index_value_i,
  input wire [4:0] data_reg_i,
  input wire fetch_advance_i,
  input wire redirect_i,
  output reg [31:0] fetch_addr_o,
  output reg [4:0] base_register_field_o,
  output reg [4:0] index_register_field_o,
  output reg ea_valid_o,
  output reg [31:0] ea_o,
  output reg [31:0] ea_last_o,
  output reg ea_wraps_o,
  output reg [3:0] ea_size_o,
  output reg mem_read_o,
  output reg mem_write_o,
  output reg fp_file_o,
  output reg [4:0] data_reg_o,
  output reg branch_taken_o,
  output reg misaligned_o,
  output reg bad_size_o
);

  // ----------------------------------------------------------------
  // Field decode
  // ----------------------------------------------------------------
  wire [`EAG_RF_W-1:0] base_field;
  wire [`EAG_RF_W-1:0] index_field;
  wire [`EAG_XLEN-1:0] disp_ext;
  wire [`EAG_XLEN-1:0] base_eff;
  wire [`EAG_XLEN-1:0] addend;
  wire [`EAG_XLEN-1:0] ea_sum;
  wire [`EAG_XLEN:0] last_full;
  wire [`EAG_XLEN-1:0] last_sum;
  wire is_int;
  wire is_fp;
  wire is_mem;
  wire size_ok;
  wire align_ok;

  // Fields sit at fixed positions so they can be sliced before full decode
  assign base_field = insn_word_i[`EAG_BASE_HI:`EAG_BASE_LO];
  assign index_field = insn_word_i[`EAG_INDEX_HI:`EAG_INDEX_LO];
  assign disp_ext = {{(`EAG_XLEN-`EAG_IMM_W){insn_word_i[`EAG_IMM_HI]}},
                     insn_word_i[`EAG_IMM_HI:`EAG_IMM_LO]};

  // Register 0 in the base slot means literal zero, not the register
  assign base_eff = (base_field == 5'h00) ? 32'h00000000 : base_value_i;
  assign addend = index_mode_i ? index_value_i : disp_ext;
  // Plain 32-bit add; the carry out is simply not kept
  assign ea_sum = base_eff + addend;

  // Last byte of the operand; wrap past the top continues at zero
  assign last_full = {1'b0, ea_sum} + {29'h00000000, access_size_i} - 33'h000000001;
  assign last_sum = last_full[`EAG_XLEN-1:0];

  assign is_int = (access_kind_i == `EAG_KIND_INT_LD) || (access_kind_i == `EAG_KIND_INT_ST);
  assign is_fp = (access_kind_i == `EAG_KIND_FP_LD) || (access_kind_i == `EAG_KIND_FP_ST);
  assign is_mem = is_int || is_fp;

  // Integer: byte/half/word; float: single/double word
  assign size_ok = is_int ? ((access_size_i == `EAG_SIZE_BYTE) ||
                             (access_size_i == `EAG_SIZE_HALF) ||
                             (access_size_i == `EAG_SIZE_WORD)) :
                   is_fp ? ((access_size_i == `EAG_SIZE_WORD) ||
                            (access_size_i == `EAG_SIZE_DWORD)) :
                   1'b1;

  // Natural alignment; misaligned accesses are only flagged, extra cycles are
  // left to the load-store unit
  assign align_ok = ((access_size_i == `EAG_SIZE_HALF) && (ea_sum[0] != 1'b0)) ? 1'b0 :
                    ((access_size_i == `EAG_SIZE_WORD) && (ea_sum[1:0] != 2'h0)) ? 1'b0 :
                    ((access_size_i == `EAG_SIZE_DWORD) && (ea_sum[2:0] != 3'h0)) ? 1'b0 :
                    1'b1;

  // ----------------------------------------------------------------
  // Address registers
  // ----------------------------------------------------------------
  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      fetch_addr_o <= `EAG_RESET_PC;
      base_register_field_o <= 5'h00;
      index_register_field_o <= 5'h00;
      ea_valid_o <= 1'b0;
      ea_o <= 32'h00000000;
      ea_last_o <= 32'h00000000;
      ea_wraps_o <= 1'b0;
      ea_size_o <= 4'h0;
      mem_read_o <= 1'b0;
      mem_write_o <= 1'b0;
      fp_file_o <= 1'b0;
      data_reg_o <= 5'h00;
      branch_taken_o <= 1'b0;
      misaligned_o <= 1'b0;
      bad_size_o <= 1'b0;
    end else begin
      // Redirect wins over sequential advance; low bits forced clear
      if (insn_valid_i && (access_kind_i == `EAG_KIND_BRANCH) && redirect_i) begin
        fetch_addr_o <= {ea_sum[31:2], 2'h0};
      end else if (fetch_advance_i) begin
        fetch_addr_o <= fetch_addr_o + `EAG_INSN_BYTES;
      end
      base_register_field_o <= base_field;
      index_register_field_o <= index_field;
      // Result registered the cycle after the operands arrive
      ea_valid_o <= insn_valid_i && (is_mem || (access_kind_i == `EAG_KIND_BRANCH));
      ea_o <= ea_sum;
      ea_last_o <= last_sum;
      ea_wraps_o <= insn_valid_i && is_mem && last_full[`EAG_XLEN];
      ea_size_o <= is_mem ? access_size_i : 4'h0;
      mem_read_o <= insn_valid_i && size_ok &&
                    ((access_kind_i == `EAG_KIND_INT_LD) || (access_kind_i == `EAG_KIND_FP_LD));
      // Only store kinds may write; ALU kind never reaches memory
      mem_write_o <= insn_valid_i && size_ok &&
                     ((access_kind_i == `EAG_KIND_INT_ST) || (access_kind_i == `EAG_KIND_FP_ST));
      fp_file_o <= insn_valid_i && is_fp;
      data_reg_o <= data_reg_i;
      branch_taken_o <= insn_valid_i && (access_kind_i == `EAG_KIND_BRANCH) && redirect_i;
      misaligned_o <= insn_valid_i && is_mem && !align_ok;
      bad_size_o <= insn_valid_i && is_mem && !size_ok;
    end
  end

endmodule // eag_effective_address_generator

// ### eag_rf_model.sv
// Register file model feeding base and index operands
`timescale 1ns/1ps
module eag_rf_model (
  input wire [31:0] insn_word_i,
  output wire [31:0] base_value_o,
  output wire [31:0] index_value_o
);
  // Entry n reads FFFFFFF0+n; entry 0 is nonzero so a missed zero base shows
  assign base_value_o = 32'hFFFFFFF0 + insn_word_i[20:16];
  assign index_value_o = 32'hFFFFFFF0 + insn_word_i[15:11];
endmodule // eag_rf_model

// ### eag_props.sv
// Port checker for the address generator
`timescale 1ns/1ps
module eag_props (
  input wire clk_i,
  input wire sys_rst_i,
  input wire insn_valid_i,
  input wire [31:0] insn_word_i,
  input wire [2:0] access_kind_i,
  input wire index_mode_i,
  input wire [31:0] base_value_i,
  input wire [31:0] index_value_i,
  input wire fetch_advance_i,
  input wire redirect_i,
  input wire [31:0] fetch_addr_o,
  input wire [31:0] ea_o,
  input wire [31:0] ea_last_o,
  input wire ea_wraps_o,
  input wire [3:0] ea_size_o,
  input wire mem_read_o,
  input wire mem_write_o,
  input wire ea_valid_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  wire [31:0] base_w = insn_word_i[20:16] == 5'h00 ? 32'h0 : base_value_i;
  wire [31:0] imm_w = base_w + {{16{insn_word_i[15]}}, insn_word_i[15:0]};
  wire [31:0] idx_w = base_w + index_value_i;
  wire mk = insn_valid_i && access_kind_i >= 3'h1 && access_kind_i <= 3'h4;
  wire mw = mem_read_o || mem_write_o;
  property p_al; fetch_addr_o[1:0] == 2'h0; endproperty
  a_al: assert property (p_al) else $error("fetch unaligned");
  property p_adv; fetch_advance_i && !redirect_i |=> fetch_addr_o == $past(fetch_addr_o) + 32'h4;
  endproperty
  a_adv: assert property (p_adv) else $error("fetch step");
  property p_imm; mk && !index_mode_i |=> ea_o == $past(imm_w); endproperty
  a_imm: assert property (p_imm) else $error("imm sum");
  property p_idx; mk && index_mode_i |=> ea_o == $past(idx_w); endproperty
  a_idx: assert property (p_idx) else $error("index sum");
  property p_lat; mk && access_kind_i == 3'h1 |=> ea_valid_o; endproperty
  a_lat: assert property (p_lat) else $error("late");
  property p_last; mw |-> ea_last_o == ea_o + {28'h0, ea_size_o} - 32'h1; endproperty
  a_last: assert property (p_last) else $error("last byte");
  property p_wr; mw |-> ea_wraps_o == (ea_last_o < ea_o); endproperty
  a_wr: assert property (p_wr) else $error("wrap flag");
  property p_alu; insn_valid_i && access_kind_i == 3'h6 |=> !mw && !ea_valid_o; endproperty
  a_alu: assert property (p_alu) else $error("alu access");
endmodule // eag_props
bind eag_effective_address_generator eag_props i_props (.*);

// ### tb.sv
// Self-checking bench for the address generator
`timescale 1ns/1ps
module tb;
  reg clk_i = 1'b0, sys_rst_i = 1'b1, insn_valid_i = 1'b0, index_mode_i = 1'b0;
  reg fetch_advance_i = 1'b0, redirect_i = 1'b0;
  reg [31:0] insn_word_i = 32'h0;
  reg [2:0] access_kind_i = 3'h0;
  reg [3:0] access_size_i = 4'h0;
  reg [4:0] data_reg_i = 5'h00;
  wire [31:0] base_value_i, index_value_i, fetch_addr_o, ea_o, ea_last_o;
  wire [4:0] base_register_field_o, index_register_field_o, data_reg_o;
  wire [3:0] ea_size_o;
  wire ea_valid_o, ea_wraps_o, mem_read_o, mem_write_o, fp_file_o, branch_taken_o;
  wire misaligned_o, bad_size_o;
  integer err_count = 0, comparisons = 0, cycles = 0;
  eag_rf_model i_rf (.insn_word_i(insn_word_i), .base_value_o(base_value_i),
    .index_value_o(index_value_i));
  eag_effective_address_generator i_dut (.*);
  initial forever #10 clk_i = ~clk_i;
  // Whole run is under 100 cycles, so 500 means a hang
  always @(posedge clk_i) begin
    cycles = cycles + 1;
    if (cycles == 500) begin
      err_count = err_count + 1;
      finish_test;
    end
  end
  task chk(input [71:0] seen, input [71:0] exp);
    begin
      comparisons = comparisons + 1;
      if (seen !== exp) begin
        err_count = err_count + 1;
        $display("Error %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task go(input [2:0] k, input [3:0] s, input m, input [31:0] w);
    begin
      @(posedge clk_i);
      #1 {insn_valid_i, access_kind_i, access_size_i, index_mode_i} = {1'b1, k, s, m};
      insn_word_i = w;
      data_reg_i = w[25:21];
      @(posedge clk_i);
      #1 insn_valid_i = 1'b0;
    end
  endtask
  task s_fetch;
    begin
      @(posedge clk_i);
      #1 fetch_advance_i = 1'b1;
      repeat (2) @(posedge clk_i);
      #1 fetch_advance_i = 1'b0;
      chk(fetch_addr_o, 32'h00000008);
      redirect_i = 1'b1;
      go(3'h5, 4'h0, 1'b0, 32'h00000102);
      redirect_i = 1'b0;
      chk({branch_taken_o, ea_o}, 33'h100000102);
      chk(fetch_addr_o, 32'h00000100);
    end
  endtask
  task s_addr;
    begin
      go(3'h1, 4'h4, 1'b0, 32'h0003000D);
      chk({base_register_field_o, ea_o}, 37'h0300000000);
      go(3'h2, 4'h4, 1'b0, 32'h0000FFFC);
      chk({mem_write_o, ea_o, ea_last_o}, 65'h1FFFFFFFCFFFFFFFF);
      go(3'h3, 4'h8, 1'b1, 32'h00E22000);
      chk({fp_file_o, data_reg_o, ea_o, ea_last_o}, 70'h27FFFFFFE6FFFFFFED);
      chk({index_register_field_o, ea_size_o, misaligned_o}, 10'h091);
      go(3'h1, 4'h4, 1'b0, 32'h000E0000);
      chk({ea_wraps_o, misaligned_o, ea_last_o}, 34'h300000001);
    end
  endtask
  task s_refuse;
    begin
      go(3'h6, 4'h4, 1'b0, 32'h00030000);
      chk({ea_valid_o, mem_read_o, mem_write_o}, 3'h0);
      go(3'h1, 4'h8, 1'b0, 32'h00030000);
      chk({bad_size_o, mem_read_o}, 2'h2);
      go(3'h2, 4'h1, 1'b0, 32'h00030000);
      chk({bad_size_o, mem_write_o}, 2'h1);
      go(3'h4, 4'h2, 1'b0, 32'h00030000);
      chk({bad_size_o, mem_write_o}, 2'h2);
    end
  endtask
  task finish_test;
    begin
      if (err_count == 0 && comparisons > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask
  initial begin
    repeat (20) @(posedge clk_i);
    #1 sys_rst_i = 1'b0;
    s_fetch;
    s_addr;
    s_refuse;
    finish_test;
  end
endmodule // tb
